// >>> ext_ctrl_port.sv
// External control handshake port with APB register access
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ext_ctrl_port
  import ext_ctrl_pkg::*;
#(
  parameter logic [16:0] MS_CYCLES = 17'(MS_CYCLES_DEF)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic [6:0] panelSelectCode,
  input wire logic measureTriggerIn,
  input wire logic selfCalIn,
  input wire logic zeroAdjustIn,
  input wire logic printIn,
  input wire logic manualJudgeEnableIn,
  // Output pins
  output logic eocOut,
  output logic indexOut,
  output logic faultOut,
  output logic resVerdictHigh,
  output logic resVerdictPass,
  output logic resVerdictLow,
  output logic voltVerdictHigh,
  output logic voltVerdictPass,
  output logic voltVerdictLow,
  output logic combinedPass,
  output logic [9:0] generalOutputWord,
  // Measurement engine status
  input wire logic measuring,
  input wire logic measDone,
  input wire logic measFault,
  input wire logic contactFault,
  input wire logic cmpResHigh,
  input wire logic cmpResPass,
  input wire logic cmpResLow,
  input wire logic cmpVoltHigh,
  input wire logic cmpVoltPass,
  input wire logic cmpVoltLow,
  // Measurement engine requests
  output logic measureStart,
  output logic panelLoad,
  output logic [6:0] panelNumber,
  output logic calStart,
  output logic calBusy,
  output logic zeroAdjustStart,
  output logic printStart,
  output logic statsTrigger,
  output logic judgeEnable
);
  typedef enum {CTL_IDLE, CTL_SETTLE} ctl_state_t;

  function automatic logic codeLoadable(input logic [6:0] code);
    codeLoadable = (code != CODE_ONES) && (code != CODE_ZEROS);
  endfunction : codeLoadable

  function automatic logic addrMapped(input logic [7:0] addr);
    addrMapped = (addr == OFS_CONFIG) || (addr == OFS_EOC_WIDTH) || (addr == OFS_GEN_OUT) ||
                 (addr == OFS_GEN_IN) || (addr == OFS_EVENTS) || (addr == OFS_PANEL);
  endfunction : addrMapped

  cond_if pins ();
  ctl_state_t state;
  logic [9:0] cfgWord;
  logic [15:0] eocWidth;
  logic [NUM_EVT-1:0] events;
  logic [NUM_EVT-1:0] evtSet;
  logic [6:0] lastCode;
  logic [16:0] msCount;
  logic msTick;
  logic [6:0] loadCount;
  logic [6:0] calCount;
  logic [15:0] eocTimer;
  logic eocTimed;
  logic busWrite;
  logic extTrig;
  logic remote;
  rate_t rate;
  qty_t qty;
  logic [6:0] code;
  logic trigFall;
  logic loadNeeded;

  // ==========================================================
  // Input conditioning
  // pins to conditioner
  assign pins.rawPins = {manualJudgeEnableIn, printIn, zeroAdjustIn, selfCalIn, measureTriggerIn, panelSelectCode};

  input_conditioner u_cond (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pins(pins)
  );

  assign extTrig = cfgWord[CFG_EXT_MEASURE_TRIGGER_IN];
  assign remote = cfgWord[CFG_REMOTE];
  assign rate = rate_t'(cfgWord[CFG_RATE_LSB +: 2]);
  assign qty = qty_t'(cfgWord[CFG_QTY_LSB +: 2]);
  assign code = pins.cleanLevel[6:0];
  assign trigFall = pins.fallPulse[IDX_MEASURE_TRIGGER_IN];
  // no load on ones or zeros
  assign loadNeeded = codeLoadable(code) && (code != lastCode) && !remote;

  // ==========================================================
  // APB slave: zero wait states, read data latched in setup
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrMapped(paddr);
  assign busWrite = psel && penable && pwrite && addrMapped(paddr);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgWord <= CONFIG_RST;
      eocWidth <= EOC_WIDTH_RST;
      generalOutputWord <= GEN_OUT_RST;
    end else if (busWrite) begin
      if (paddr == OFS_CONFIG) begin
        cfgWord <= pwdata[9:0];
      end else if (paddr == OFS_EOC_WIDTH) begin
        eocWidth <= pwdata[15:0];
      end else if (paddr == OFS_GEN_OUT) begin
        generalOutputWord <= pwdata[9:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      if (paddr == OFS_CONFIG) begin
        prdata <= {22'h00_0000, cfgWord};
      end else if (paddr == OFS_EOC_WIDTH) begin
        prdata <= {16'h0000, eocWidth};
      end else if (paddr == OFS_GEN_OUT) begin
        prdata <= {22'h00_0000, generalOutputWord};
      end else if (paddr == OFS_GEN_IN) begin
        prdata <= {27'h000_0000, pins.cleanLevel[IDX_MANUAL_JUDGE_ENABLE_IN:IDX_MEASURE_TRIGGER_IN]};
      end else if (paddr == OFS_EVENTS) begin
        prdata <= {26'h000_0000, events};
      end else if (paddr == OFS_PANEL) begin
        prdata <= {17'h0_0000, ~lastCode, 1'b0, lastCode};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Sticky event log; a new event wins over a clear in the same cycle
  assign evtSet = {statsTrigger, printStart, zeroAdjustStart, calStart, measureStart, panelLoad};
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      events <= '0;
    end else if (busWrite && paddr == OFS_EVENTS) begin
      events <= (events & ~pwdata[NUM_EVT-1:0]) | evtSet;
    end else begin
      events <= events | evtSet;
    end
  end

  // ==========================================================
  // Millisecond tick
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msCount <= 17'h0_0000;
      msTick <= 1'b0;
    end else if (msCount >= MS_CYCLES - 17'h0_0001) begin
      msCount <= 17'h0_0000;
      msTick <= 1'b1;
    end else begin
      msCount <= msCount + 17'h0_0001;
      msTick <= 1'b0;
    end
  end

  // ==========================================================
  // Trigger and panel load sequencer
  // Triggers arriving during a load settle are dropped; the engine is busy anyway
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CTL_IDLE;
      lastCode <= CODE_ONES;
      loadCount <= 7'h00;
      panelLoad <= 1'b0;
      panelNumber <= 7'h00;
      measureStart <= 1'b0;
      statsTrigger <= 1'b0;
    end else begin
      panelLoad <= 1'b0;
      measureStart <= 1'b0;
      statsTrigger <= 1'b0;
      case (state)
        CTL_IDLE: begin
          if (trigFall) begin
            lastCode <= code;
            statsTrigger <= 1'b1;
            if (loadNeeded) begin
              panelNumber <= ~code;
              panelLoad <= 1'b1;
              loadCount <= LOAD_TICKS;
              state <= CTL_SETTLE;
            end else if (extTrig) begin
              measureStart <= 1'b1;
            end
          end
        end
        CTL_SETTLE: begin
          if (msTick) begin
            if (loadCount <= 7'h01) begin
              measureStart <= extTrig;
              state <= CTL_IDLE;
            end else begin
              loadCount <= loadCount - 7'h01;
            end
          end
        end
        default: begin
          state <= CTL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Self-calibration, zero adjust, print
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      calStart <= 1'b0;
      calBusy <= 1'b0;
      calCount <= 7'h00;
    end else begin
      calStart <= 1'b0;
      if (pins.fallPulse[IDX_CAL] && cfgWord[CFG_MANUAL_CAL] && rate != RATE_SLOWEST && !calBusy) begin
        calStart <= 1'b1;
        calBusy <= 1'b1;
        calCount <= CAL_TICKS;
      end else if (calBusy && msTick) begin
        if (calCount <= 7'h01) begin
          calBusy <= 1'b0;
        end else begin
          calCount <= calCount - 7'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      zeroAdjustStart <= 1'b0;
      printStart <= 1'b0;
    end else begin
      zeroAdjustStart <= pins.fallPulse[IDX_ZERO];
      printStart <= pins.fallPulse[IDX_PRINT];
    end
  end

  assign judgeEnable = !cfgWord[CFG_CMP_MANUAL] || !pins.cleanLevel[IDX_MANUAL_JUDGE_ENABLE_IN];

  // ==========================================================
  // End-of-conversion and probe-release indicator
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eocOut <= 1'b1;
      eocTimed <= 1'b0;
      eocTimer <= 16'h0000;
    end else if (measDone) begin
      eocOut <= 1'b1;
      if (cfgWord[CFG_EOC_PULSE]) begin
        eocTimed <= 1'b1;
        eocTimer <= eocWidth;
      end else if (!extTrig) begin
        eocTimed <= 1'b1;
        case (rate)
          RATE_FASTEST: eocTimer <= EOC_HOLD_FASTEST;
          RATE_FAST: eocTimer <= EOC_HOLD_FAST;
          RATE_MIDDLE: eocTimer <= EOC_HOLD_MIDDLE;
          default: eocTimer <= EOC_HOLD_SLOWEST;
        endcase
      end else begin
        eocTimed <= 1'b0;
      end
    end else if (trigFall && extTrig && !cfgWord[CFG_EOC_PULSE]) begin
      eocOut <= 1'b0;
      eocTimed <= 1'b0;
    end else if (eocTimed && msTick) begin
      if (eocTimer <= 16'h0001) begin
        eocOut <= 1'b0;
        eocTimed <= 1'b0;
      end else begin
        eocTimer <= eocTimer - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      indexOut <= 1'b1;
    end else begin
      indexOut <= !measuring;
    end
  end

  // ==========================================================
  // Verdicts and fault flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {resVerdictHigh, resVerdictPass, resVerdictLow} <= 3'h0;
      {voltVerdictHigh, voltVerdictPass, voltVerdictLow} <= 3'h0;
      combinedPass <= 1'b0;
    end else if (measDone) begin
      {resVerdictHigh, resVerdictPass, resVerdictLow} <= {cmpResHigh, cmpResPass, cmpResLow};
      {voltVerdictHigh, voltVerdictPass, voltVerdictLow} <= {cmpVoltHigh, cmpVoltPass, cmpVoltLow};
      case (qty)
        QTY_RES: combinedPass <= cmpResPass;
        QTY_VOLT: combinedPass <= cmpVoltPass;
        default: combinedPass <= cmpResPass && cmpVoltPass;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      faultOut <= 1'b0;
    end else if (cfgWord[CFG_FAULT_LIVE]) begin
      faultOut <= contactFault;
    end else if (measDone) begin
      faultOut <= measFault;
    end
  end

  // ==========================================================
  // Checks
  AST_NO_LOAD_BAD_CODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == CTL_IDLE && trigFall && !codeLoadable(code) |=> !panelLoad)
    else $error("panel load on all-ones or all-zeros code");
  AST_SAME_CODE_MEASURES: assert property (@(posedge ref_clk) disable iff (!rst_b)
    state == CTL_IDLE && trigFall && code == lastCode && extTrig |=> !panelLoad && measureStart)
    else $error("repeated code did not give a plain measurement");
  AST_SETTLE_MIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
    panelLoad |-> state == CTL_SETTLE && loadCount == LOAD_TICKS)
    else $error("panel load did not arm the settle timer");
  AST_REMOTE_NO_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    trigFall && remote |=> !panelLoad)
    else $error("panel load while remote");
  AST_INT_MEASURE_TRIGGER_IN_NO_START: assert property (@(posedge ref_clk) disable iff (!rst_b)
    trigFall && !extTrig && state == CTL_IDLE |=> statsTrigger && !measureStart)
    else $error("internal mode trigger misrouted");
  AST_CAL_SLOW_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pins.fallPulse[IDX_CAL] && rate == RATE_SLOWEST |=> !calStart)
    else $error("calibration started at slowest rate");
  AST_ZERO_ONCE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pins.fallPulse[IDX_ZERO] |=> zeroAdjustStart ##1 !zeroAdjustStart)
    else $error("zero adjust not exactly one pulse");
  AST_GEN_OUT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !(busWrite && paddr == OFS_GEN_OUT) |=> $stable(generalOutputWord))
    else $error("general outputs changed without a write");
  AST_INDEX_MEASURING: assert property (@(posedge ref_clk) disable iff (!rst_b)
    measuring [*2] |-> !indexOut)
    else $error("indicator on while measuring");
  AST_SYNC_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !cfgWord[CFG_FAULT_LIVE] && measDone |=> faultOut == $past(measFault))
    else $error("synchronous fault not taken at completion");
  AST_COMBINED_DUAL: assert property (@(posedge ref_clk) disable iff (!rst_b)
    measDone && qty == QTY_DUAL |=> combinedPass == (resVerdictPass && voltVerdictPass))
    else $error("combined pass wrong in dual mode");
endmodule : ext_ctrl_port
`default_nettype wire

// >>> ext_ctrl_pkg.sv
// Constants, field layouts and types shared by the external control port
package ext_ctrl_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_FREQ_HZ / MS_PER_S;
  localparam int LOAD_SETTLE_MS = 70;
  localparam int CAL_TIME_MS = 55;
  localparam int MEASURE_TRIGGER_IN_MIN_US = 500;
  localparam int FILTER_NS = 80;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] FILTER_LAST = 4'(FILTER_CYCLES - 1);
  localparam logic [6:0] LOAD_TICKS = 7'(LOAD_SETTLE_MS + 1);
  localparam logic [6:0] CAL_TICKS = 7'(CAL_TIME_MS + 1);
  localparam logic [15:0] EOC_HOLD_FASTEST = 16'h0001;
  localparam logic [15:0] EOC_HOLD_FAST = 16'h0005;
  localparam logic [15:0] EOC_HOLD_MIDDLE = 16'h0014;
  localparam logic [15:0] EOC_HOLD_SLOWEST = 16'h0032;
  // ==========================================================
  // Pins
  localparam int NUM_PINS = 12;
  localparam int IDX_MEASURE_TRIGGER_IN = 7;
  localparam int IDX_CAL = 8;
  localparam int IDX_ZERO = 9;
  localparam int IDX_PRINT = 10;
  localparam int IDX_MANUAL_JUDGE_ENABLE_IN = 11;
  localparam logic [6:0] CODE_ONES = 7'h7F;
  localparam logic [6:0] CODE_ZEROS = 7'h00;
  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_EOC_WIDTH = 8'h04;
  localparam logic [7:0] OFS_GEN_OUT = 8'h08;
  localparam logic [7:0] OFS_GEN_IN = 8'h0C;
  localparam logic [7:0] OFS_EVENTS = 8'h10;
  localparam logic [7:0] OFS_PANEL = 8'h14;
  localparam int CFG_EXT_MEASURE_TRIGGER_IN = 0;
  localparam int CFG_MANUAL_CAL = 1;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_FAULT_LIVE = 4;
  localparam int CFG_EOC_PULSE = 5;
  localparam int CFG_CMP_MANUAL = 6;
  localparam int CFG_REMOTE = 7;
  localparam int CFG_QTY_LSB = 8;
  localparam logic [9:0] CONFIG_RST = 10'h01C;
  localparam logic [15:0] EOC_WIDTH_RST = 16'h0001;
  localparam logic [9:0] GEN_OUT_RST = 10'h000;
  localparam int EVT_LOAD = 0;
  localparam int EVT_MEAS = 1;
  localparam int EVT_CAL = 2;
  localparam int EVT_ZERO = 3;
  localparam int EVT_PRINT = 4;
  localparam int EVT_STATS = 5;
  localparam int NUM_EVT = 6;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {RATE_FASTEST, RATE_FAST, RATE_MIDDLE, RATE_SLOWEST} rate_t;
  typedef enum logic [1:0] {QTY_DUAL, QTY_RES, QTY_VOLT, QTY_RSVD} qty_t;
endpackage : ext_ctrl_pkg

// >>> cond_if.sv
// Raw and conditioned pin levels between the port and its input conditioner
`timescale 1ns/1ps
`default_nettype none
interface cond_if;
  import ext_ctrl_pkg::*;
  logic [NUM_PINS-1:0] rawPins;
  logic [NUM_PINS-1:0] cleanLevel;
  logic [NUM_PINS-1:0] fallPulse;
  modport src (output rawPins, input cleanLevel, input fallPulse);
  modport cond (input rawPins, output cleanLevel, output fallPulse);
endinterface : cond_if
`default_nettype wire

// >>> input_conditioner.sv
// Synchroniser, glitch filter and falling-edge detector for the control pins
`timescale 1ns/1ps
`default_nettype none
module input_conditioner
  import ext_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Pins
  cond_if.cond pins
);
  logic [NUM_PINS-1:0] syncA;
  logic [NUM_PINS-1:0] syncB;
  logic [NUM_PINS-1:0] stable;
  logic [NUM_PINS-1:0] prevStable;
  logic [3:0] cnt [NUM_PINS];

  // ==========================================================
  // Synchroniser
  // sync first and second stage
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA <= '1;
      syncB <= '1;
    end else begin
      syncA <= pins.rawPins;
      syncB <= syncA;
    end
  end

  // ==========================================================
  // Filter: a level must persist before it is believed
  // stable level filter
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stable <= '1;
      prevStable <= '1;
      for (int i = 0; i < NUM_PINS; i++) begin
        cnt[i] <= 4'h0;
      end
    end else begin
      prevStable <= stable;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (syncB[i] == stable[i]) begin
          cnt[i] <= 4'h0;
        end else if (cnt[i] == FILTER_LAST) begin
          stable[i] <= syncB[i];
          cnt[i] <= 4'h0;
        end else begin
          cnt[i] <= cnt[i] + 4'h1;
        end
      end
    end
  end

  assign pins.cleanLevel = stable;
  assign pins.fallPulse = prevStable & ~stable;

  AST_ONE_PULSE_PER_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pins.fallPulse[IDX_MEASURE_TRIGGER_IN] |=> !pins.fallPulse[IDX_MEASURE_TRIGGER_IN])
    else $error("trigger edge pulse longer than one cycle");
endmodule : input_conditioner
`default_nettype wire

// >>> plc_model.sv
// Handler model that drives the select code and the control strobes
`timescale 1ns/1ps
`default_nettype none
module plc_model (
  // Clock
  input wire logic ref_clk,
  // Pins, open lines idle high
  output logic [6:0] panelSelectCode,
  output logic [4:0] ctl
);
  // ==========================================================
  // Drive
  initial begin
    panelSelectCode = 7'h7F;
    ctl = 5'h1F;
  end
  task automatic setCode(input logic [6:0] c);
    @(posedge ref_clk);
    panelSelectCode <= c;
    repeat (20) @(posedge ref_clk);
  endtask : setCode
  // low well past half a millisecond
  task automatic strobe(input int idx);
    @(posedge ref_clk);
    ctl[idx] <= 1'b0;
    repeat (30) @(posedge ref_clk);
    ctl[idx] <= 1'b1;
    repeat (30) @(posedge ref_clk);
  endtask : strobe
endmodule : plc_model
`default_nettype wire

// >>> ext_ctrl_port_tb.sv
// Self-checking bench for the external control port
`timescale 1ns/1ps
`default_nettype none
module ext_ctrl_port_tb;
  import ext_ctrl_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, seed;
  logic [6:0] panelSelectCode, panelNumber, code, lastNum, v;
  logic [6:0] bad [3];
  logic [4:0] ctl;
  logic [9:0] generalOutputWord;
  logic eocOut, indexOut, faultOut, resVerdictHigh, resVerdictPass, resVerdictLow;
  logic voltVerdictHigh, voltVerdictPass, voltVerdictLow, combinedPass, judgeEnable;
  logic measuring, measDone, measFault, contactFault, cmpResHigh, cmpResPass, cmpResLow;
  logic cmpVoltHigh, cmpVoltPass, cmpVoltLow, measureStart, panelLoad, calStart, calBusy;
  logic zeroAdjustStart, printStart, statsTrigger;
  int num_errors, checks, nMeas, nLoad, nCal, nZero, nPrint, nStats, m, s;
  plc_model i_plc_model (.ref_clk(ref_clk), .panelSelectCode(panelSelectCode), .ctl(ctl));
  ext_ctrl_port #(.MS_CYCLES(17'h0_0014)) i_ext_ctrl_port (.*, .measureTriggerIn(ctl[0]),
    .selfCalIn(ctl[1]), .zeroAdjustIn(ctl[2]), .printIn(ctl[3]), .manualJudgeEnableIn(ctl[4]));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    nMeas <= nMeas + int'(measureStart === 1'b1);
    nLoad <= nLoad + int'(panelLoad === 1'b1);
    nCal <= nCal + int'(calStart === 1'b1);
    nZero <= nZero + int'(zeroAdjustStart === 1'b1);
    nPrint <= nPrint + int'(printStart === 1'b1);
    nStats <= nStats + int'(statsTrigger === 1'b1);
    if (panelLoad === 1'b1) lastNum <= panelNumber;
  end
  // ==========================================================
  // Tasks
  function automatic logic expPass(int q, logic r, logic w);
    return (q == 1) ? r : ((q == 2) ? w : (r & w));
  endfunction : expPass
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Request held until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 100) begin
      num_errors++;
      results();
    end
  endtask : apb
  task automatic conv(input logic [6:0] x);
    @(posedge ref_clk);
    measFault <= x[6];
    cmpResHigh <= x[5];
    cmpResPass <= x[4];
    cmpResLow <= x[3];
    cmpVoltHigh <= x[2];
    cmpVoltPass <= x[1];
    cmpVoltLow <= x[0];
    measuring <= 1'b1;
    tick(3);
    chk("index", indexOut, 1'h0);
    measuring <= 1'b0;
    measDone <= 1'b1;
    @(posedge ref_clk);
    measDone <= 1'b0;
    // Read one edge after completion: a millisecond tick may end a short hold soon after
    tick(1);
  endtask : conv
  // Hang guard
  initial begin
    tick(90000);
    num_errors++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h4532_3549;
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, measuring, measDone, measFault, contactFault} = '0;
    {cmpResHigh, cmpResPass, cmpResLow, cmpVoltHigh, cmpVoltPass, cmpVoltLow} = '0;
    tick(8);
    rst_b <= 1'b1;
    chk("eocRst", eocOut, 1'h1);
    chk("idxRst", indexOut, 1'h1);
    apb(OFS_CONFIG, 1'h0, 32'h0000_0000);
    chk("config", rd, 32'(CONFIG_RST));
    d = $random(seed);
    apb(OFS_GEN_OUT, 1'h1, d);
    tick(1);
    chk("genOut", generalOutputWord, d[9:0]);
    apb(8'h20, 1'h0, 32'h0000_0000);
    chk("slverr", err, 1'h1);
    apb(OFS_GEN_IN, 1'h0, 32'h0000_0000);
    chk("genIn", rd, 32'h0000_001F);
    apb(OFS_CONFIG, 1'h1, 32'h0000_0003);
    code = {1'b0, 6'($random(seed))} | 7'h01;
    i_plc_model.setCode(code);
    i_plc_model.strobe(0);
    chk("early", nMeas, 0);
    tick(1500);
    chk("meas", nMeas, 1);
    chk("panel", lastNum, 7'(~code));
    bad = '{code, 7'h7F, 7'h00};
    foreach (bad[i]) begin
      i_plc_model.setCode(bad[i]);
      i_plc_model.strobe(0);
      tick(20);
      chk("noLoad", nLoad, 1);
      chk("measN", nMeas, i + 2);
    end
    apb(OFS_CONFIG, 1'h1, 32'h0000_0083);
    i_plc_model.setCode(code ^ 7'h02);
    i_plc_model.strobe(0);
    tick(1500);
    chk("remote", nLoad, 1);
    apb(OFS_CONFIG, 1'h1, 32'h0000_0002);
    m = nMeas;
    s = nStats;
    i_plc_model.strobe(0);
    tick(20);
    chk("intMeas", nMeas, m);
    chk("stats", nStats, s + 1);
    for (int i = 1; i < 4; i++) i_plc_model.strobe(i);
    chk("busy", calBusy, 1'h1);
    tick(1200);
    chk("calDone", calBusy, 1'h0);
    chk("cal", nCal, 1);
    chk("zero", nZero, 1);
    chk("print", nPrint, 1);
    apb(OFS_CONFIG, 1'h1, 32'h0000_004E);
    i_plc_model.strobe(1);
    chk("calSlow", nCal, 1);
    fork
      i_plc_model.strobe(4);
      begin
        tick(20);
        chk("judgeLo", judgeEnable, 1'h1);
      end
    join
    chk("judgeHi", judgeEnable, 1'h0);
    // results latched at end of conversion
    for (int q = 0; q < 4; q++) begin
      apb(OFS_CONFIG, 1'h1, (32'(q) << CFG_QTY_LSB) | 32'h0000_0002);
      v = 7'($random(seed));
      conv(v);
      chk("eoc", eocOut, 1'h1);
      chk("fault", faultOut, v[6]);
      chk("verdict", {resVerdictHigh, resVerdictPass, resVerdictLow, voltVerdictHigh, voltVerdictPass,
        voltVerdictLow}, v[5:0]);
      chk("and", combinedPass, expPass(q, v[4], v[1]));
    end
    // pulse mode holds for the programmed width only
    apb(OFS_EOC_WIDTH, 1'h1, 32'h0000_0003);
    apb(OFS_CONFIG, 1'h1, 32'h0000_0022);
    conv(v);
    tick(25);
    chk("pulseOn", eocOut, 1'h1);
    tick(40);
    chk("pulseOff", eocOut, 1'h0);
    apb(OFS_EVENTS, 1'h0, 32'h0000_0000);
    chk("events", rd, 32'h0000_003F);
    apb(OFS_EVENTS, 1'h1, 32'h0000_003F);
    apb(OFS_EVENTS, 1'h0, 32'h0000_0000);
    chk("evtClr", rd, 32'h0000_0000);
    apb(OFS_PANEL, 1'h0, 32'h0000_0000);
    chk("panelReg", rd, {17'h0_0000, 7'(~(code ^ 7'h02)), 1'b0, code ^ 7'h02});
    contactFault <= ~v[6];
    tick(3);
    chk("syncHold", faultOut, v[6]);
    apb(OFS_CONFIG, 1'h1, 32'h0000_0012);
    tick(2);
    chk("live", faultOut, 1'(~v[6]));
    chk("genKeep", generalOutputWord, d[9:0]);
    results();
  end
endmodule : ext_ctrl_port_tb
`default_nettype wire
